/* rtl/pbm_pkg.sv */
// Package for the port pin function multiplexer: bit positions, widths and reset values.
// Assumes a single core clock domain and that pbm_pin_sync and pbm_mux import this package.
package pbm_pkg;
  // Number of port bits handled by this block (bits 1 to 5).
  localparam int PBM_NBITS = 5;
  // Index of each port bit inside the five-bit vectors (vector bit 0 is port bit 1).
  localparam int PBM_B1 = 0;
  localparam int PBM_B2 = 1;
  localparam int PBM_B3 = 2;
  localparam int PBM_B4 = 3;
  localparam int PBM_B5 = 4;
  // Number of pins with analog capability (port bits 1 to 4).
  localparam int PBM_NANA = 4;
  // Analog converter channel numbers reached by port bits 1 to 4.
  localparam logic [3:0] PBM_CH_B1 = 4'ha;
  localparam logic [3:0] PBM_CH_B2 = 4'h8;
  localparam logic [3:0] PBM_CH_B3 = 4'h9;
  localparam logic [3:0] PBM_CH_B4 = 4'hb;
  // Direction code that makes a pin an output, and the code that makes it an input.
  localparam logic PBM_DIR_OUT = 1'b0;
  localparam logic PBM_DIR_IN = 1'b1;
  // Pin mapping code that places the second capture unit on port bit 3.
  localparam logic PBM_CCP_ON_B3 = 1'b0;
  // Reset values.
  localparam logic [4:0] PBM_RST_VEC = 5'h00;
  localparam logic [3:0] PBM_RST_ANA = 4'h0;
  localparam logic [3:0] PBM_ANA_ALL = 4'hf;
  // Synchroniser reset value.
  localparam logic [2:0] PBM_SYNC_RST = 3'h0;
endpackage

/* rtl/pbm_sync_if.sv */
// Interface carrying raw pin levels into the synchroniser and stable levels back out.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
interface pbm_sync_if;
  // Raw, asynchronous pin levels.
  logic [4:0] raw;
  // Filtered levels, updated once two late stages agree.
  logic [4:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

/* rtl/pbm_pin_sync.sv */
// Three-stage synchroniser for the pin inputs with an agreement filter.
// Assumes core_clk domain; raw inputs may change at any time.
`timescale 1ns/10ps
module pbm_pin_sync (
  // Clock, reset and enable.
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Pin levels in and out.
  pbm_sync_if.sync sif
);
  import pbm_pkg::*;

  // Per-bit synchroniser chains and accepted levels.
  logic [2:0] stage [PBM_NBITS];
  logic [2:0] next_stage [PBM_NBITS];
  logic [PBM_NBITS-1:0] level;
  logic [PBM_NBITS-1:0] next_level;

  // One generate loop builds the chain for each bit.
  for (genvar i = 0; i < PBM_NBITS; i++) begin : g_bit
    // The first flop feeds only the second; the filter looks at the second and third.
    always_comb begin
      next_stage[i] = stage[i];
      next_level[i] = level[i];
      if (clk_en) begin
        next_stage[i] = {stage[i][1:0], sif.raw[i]};
        if (stage[i][1] == stage[i][2]) begin
          next_level[i] = stage[i][2];
        end
      end
    end

    // Registers for the chain and the accepted level.
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        stage[i] <= PBM_SYNC_RST;
        level[i] <= 1'b0;
      end else begin
        stage[i] <= next_stage[i];
        level[i] <= next_level[i];
      end
    end
  end

  assign sif.clean = level;
endmodule

/* rtl/pbm_mux.sv */
// Pin function multiplexer for port bits 1 to 5 of an eight-bit general-purpose port.
// Assumes pins arrive from outside the core_clk domain and peripherals sit on core_clk.
`timescale 1ns/10ps
module pbm_mux #(
  // Set for the larger package that bonds out the parallel port chip select.
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // Clock, reset and enable.
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Port control from software, bit 0 is port bit 1.
  input wire logic [pbm_pkg::PBM_NBITS-1:0] output_latch,
  input wire logic [pbm_pkg::PBM_NBITS-1:0] direction_bits,
  input wire logic pullup_disable_bit,
  input wire logic [pbm_pkg::PBM_NANA-1:0] analog_select_wr,
  input wire logic analog_select_we,
  // Configuration bits.
  input wire logic analog_default_config,
  input wire logic capture_unit_pin_select,
  input wire logic low_voltage_program_config,
  // Serial module.
  input wire logic spi_mode,
  input wire logic i2c_mode,
  input wire logic serial_clk_out,
  input wire logic i2c_smbus_levels,
  // Transceiver, capture unit and parallel port.
  input wire logic xcvr_ext_mode,
  input wire logic xcvr_minus_data,
  input wire logic xcvr_plus_data,
  input wire logic capture_unit_two_en,
  input wire logic capture_unit_two_out,
  input wire logic parallel_chip_sel_en,
  input wire logic parallel_chip_sel,
  // Pins.
  input wire logic [pbm_pkg::PBM_NBITS-1:0] pin_in,
  output logic [pbm_pkg::PBM_NBITS-1:0] pin_out,
  output logic [pbm_pkg::PBM_NBITS-1:0] pin_oe,
  output logic [pbm_pkg::PBM_NBITS-1:0] pin_pullup,
  output logic [pbm_pkg::PBM_NANA-1:0] analog_enable,
  // Results toward the core.
  output logic [pbm_pkg::PBM_NBITS-1:0] port_input_value,
  output logic [pbm_pkg::PBM_NANA-1:0] analog_channel_map,
  output logic [3:0] analog_channel_num,
  output logic serial_clk_in,
  output logic serial_clk_smbus,
  output logic external_interrupt_one,
  output logic external_interrupt_two,
  output logic capture_unit_two,
  output logic change_interrupt_pin_zero,
  output logic change_interrupt_pin_one,
  output logic low_voltage_program_entry
);
  import pbm_pkg::*;

  // Synchronised pin levels.
  pbm_sync_if sif ();
  logic [PBM_NBITS-1:0] pin_s;

  // Analog selection register, one bit per analog-capable pin.
  logic [PBM_NANA-1:0] ana_sel;
  logic [PBM_NANA-1:0] next_ana_sel;
  // Strap catch: reset state of the analog selection is loaded after release.
  logic strap_done;
  logic next_strap_done;

  // Combinational pin drive and core-facing values.
  logic [PBM_NBITS-1:0] next_pin_out;
  logic [PBM_NBITS-1:0] next_pin_oe;
  logic [PBM_NBITS-1:0] next_pin_pullup;
  logic [PBM_NBITS-1:0] next_port_in;
  logic [PBM_NANA-1:0] next_ana_map;
  logic [3:0] next_ana_num;
  logic next_sclk_in;
  logic next_sclk_smb;
  logic next_external_interrupt_one;
  logic next_external_interrupt_two;
  logic next_cap;
  logic next_change_interrupt_pin_zero;
  logic next_change_interrupt_pin_one;
  logic next_prog;
  logic ccp_here;
  logic [PBM_NBITS-1:0] dig_in_ok;

  assign sif.raw = pin_in;
  assign pin_s = sif.clean;

  // Three-flop synchroniser on every pin input.
  pbm_pin_sync u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .sif(sif)
  );

  // Analog selection: strap value once after reset, then software writes.
  always_comb begin
    next_ana_sel = ana_sel;
    next_strap_done = strap_done;
    if (clk_en) begin
      if (!strap_done) begin
        next_ana_sel = analog_default_config ? PBM_ANA_ALL : PBM_RST_ANA;
        next_strap_done = 1'b1;
      end else if (analog_select_we) begin
        next_ana_sel = analog_select_wr;
      end
    end
  end

  // Registers for the analog selection state.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ana_sel <= PBM_RST_ANA;
      strap_done <= 1'b0;
    end else begin
      ana_sel <= next_ana_sel;
      strap_done <= next_strap_done;
    end
  end

  // Pin function selection for each bit.
  always_comb begin
    // Default port path: latch drives when direction is output.
    next_pin_out = output_latch;
    next_pin_oe = ~direction_bits;
    ccp_here = capture_unit_two_en && (capture_unit_pin_select == PBM_CCP_ON_B3);
    // Bit 1: serial clock output overrides latch in either serial mode.
    if ((spi_mode || i2c_mode) && direction_bits[PBM_B1] == PBM_DIR_OUT) begin
      next_pin_out[PBM_B1] = serial_clk_out;
    end
    // Bits 2 and 3: external transceiver data outputs.
    if (xcvr_ext_mode && direction_bits[PBM_B2] == PBM_DIR_OUT) begin
      next_pin_out[PBM_B2] = xcvr_minus_data;
    end
    if (xcvr_ext_mode && direction_bits[PBM_B3] == PBM_DIR_OUT) begin
      next_pin_out[PBM_B3] = xcvr_plus_data;
    end else if (ccp_here && direction_bits[PBM_B3] == PBM_DIR_OUT) begin
      next_pin_out[PBM_B3] = capture_unit_two_out;
    end
    // Bit 4: parallel port chip select on the larger package.
    if (LARGE_PACKAGE && parallel_chip_sel_en && direction_bits[PBM_B4] == PBM_DIR_OUT) begin
      next_pin_out[PBM_B4] = parallel_chip_sel;
    end
    // Bit 5: programming entry takes the pin as input only.
    if (low_voltage_program_config) begin
      next_pin_oe[PBM_B5] = 1'b0;
      next_pin_out[PBM_B5] = 1'b0;
    end
    // Weak pull-ups only on inputs, only while the global disable is clear.
    next_pin_pullup = (pullup_disable_bit ? PBM_RST_VEC : ~PBM_RST_VEC) & ~next_pin_oe;
    if (low_voltage_program_config) begin
      next_pin_pullup[PBM_B5] = 1'b0;
    end
    // Digital input path is blocked on analog pins and on the programming pin.
    dig_in_ok = {~low_voltage_program_config, ~ana_sel};
    next_port_in = pin_s & dig_in_ok & direction_bits;
    // Analog channels connect only with direction input.
    next_ana_map = ana_sel & direction_bits[PBM_NANA-1:0];
    next_ana_num = PBM_CH_B1;
    if (next_ana_map[PBM_B1]) begin
      next_ana_num = PBM_CH_B1;
    end else if (next_ana_map[PBM_B2]) begin
      next_ana_num = PBM_CH_B2;
    end else if (next_ana_map[PBM_B3]) begin
      next_ana_num = PBM_CH_B3;
    end else if (next_ana_map[PBM_B4]) begin
      next_ana_num = PBM_CH_B4;
    end
    // Peripheral inputs, taken when the direction is input; the SMBus level select and programming entry ignore direction.
    next_sclk_in = pin_s[PBM_B1] & direction_bits[PBM_B1] & (spi_mode | i2c_mode);
    next_sclk_smb = i2c_smbus_levels & i2c_mode;
    next_external_interrupt_one = pin_s[PBM_B1] & direction_bits[PBM_B1];
    next_external_interrupt_two = pin_s[PBM_B2] & direction_bits[PBM_B2];
    next_cap = pin_s[PBM_B3] & direction_bits[PBM_B3] & ccp_here;
    next_change_interrupt_pin_zero = pin_s[PBM_B4] & direction_bits[PBM_B4] & ~ana_sel[PBM_B4];
    next_change_interrupt_pin_one = pin_s[PBM_B5] & direction_bits[PBM_B5] & ~low_voltage_program_config;
    next_prog = pin_s[PBM_B5] & low_voltage_program_config;
  end

  // Output registers: every port output comes from a flop.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= PBM_RST_VEC;
      pin_oe <= PBM_RST_VEC;
      pin_pullup <= PBM_RST_VEC;
      analog_enable <= PBM_RST_ANA;
      port_input_value <= PBM_RST_VEC;
      analog_channel_map <= PBM_RST_ANA;
      analog_channel_num <= PBM_CH_B1;
      serial_clk_in <= 1'b0;
      serial_clk_smbus <= 1'b0;
      external_interrupt_one <= 1'b0;
      external_interrupt_two <= 1'b0;
      capture_unit_two <= 1'b0;
      change_interrupt_pin_zero <= 1'b0;
      change_interrupt_pin_one <= 1'b0;
      low_voltage_program_entry <= 1'b0;
    end else if (clk_en) begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_pullup <= next_pin_pullup;
      analog_enable <= ana_sel;
      port_input_value <= next_port_in;
      analog_channel_map <= next_ana_map;
      analog_channel_num <= next_ana_num;
      serial_clk_in <= next_sclk_in;
      serial_clk_smbus <= next_sclk_smb;
      external_interrupt_one <= next_external_interrupt_one;
      external_interrupt_two <= next_external_interrupt_two;
      capture_unit_two <= next_cap;
      change_interrupt_pin_zero <= next_change_interrupt_pin_zero;
      change_interrupt_pin_one <= next_change_interrupt_pin_one;
      low_voltage_program_entry <= next_prog;
    end
  end
endmodule

/* bench/pbm_mux_checker.sv */
// Checker for the port pin multiplexer, bound to pbm_mux.
// Assumes one core clock and a one-edge registered answer to controls.
`timescale 1ns/10ps
module pbm_mux_checker (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Controls.
  input wire logic [pbm_pkg::PBM_NBITS-1:0] output_latch,
  input wire logic [pbm_pkg::PBM_NBITS-1:0] direction_bits,
  input wire logic pullup_disable_bit,
  input wire logic low_voltage_program_config,
  input wire logic capture_unit_pin_select,
  // Peripherals.
  input wire logic spi_mode,
  input wire logic serial_clk_out,
  input wire logic xcvr_ext_mode,
  input wire logic xcvr_minus_data,
  input wire logic capture_unit_two_en,
  input wire logic capture_unit_two_out,
  input wire logic parallel_chip_sel_en,
  input wire logic parallel_chip_sel,
  // Pads.
  input wire logic [pbm_pkg::PBM_NBITS-1:0] pin_out,
  input wire logic [pbm_pkg::PBM_NBITS-1:0] pin_oe,
  input wire logic [pbm_pkg::PBM_NBITS-1:0] pin_pullup
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // High when the previous edge was enabled and out of reset, so $past is trustworthy.
  logic live;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      live <= 1'b0;
    end else begin
      live <= clk_en;
    end
  end
  pullup_off_out_a: assert property ((pin_oe & pin_pullup) == 5'h00)
    else $error("Pull-up left on a driven pin.");
  latch_drive_a: assert property (live && !$past(direction_bits[4])
    && !$past(low_voltage_program_config) |-> pin_oe[4] && pin_out[4] == $past(output_latch[4]))
    else $error("Bit five does not follow its latch.");
  pullup_on_a: assert property (live && $past(direction_bits[4]) && !$past(pullup_disable_bit)
    && !$past(low_voltage_program_config) |-> pin_pullup[4] && !pin_oe[4])
    else $error("Input pin five lacks its pull-up.");
  pullup_gate_a: assert property (live && $past(pullup_disable_bit) |-> pin_pullup == 5'h00)
    else $error("Pull-up on while disabled.");
  prog_entry_a: assert property (live && $past(low_voltage_program_config)
    |-> !pin_oe[4] && !pin_pullup[4]) else $error("Programming pin not input only.");
  spi_clk_out_a: assert property (live && $past(spi_mode && !direction_bits[0])
    |-> pin_oe[0] && pin_out[0] == $past(serial_clk_out)) else $error("Serial clock not on bit one.");
  xcvr_minus_a: assert property (live && $past(xcvr_ext_mode && !direction_bits[1])
    |-> pin_oe[1] && pin_out[1] == $past(xcvr_minus_data)) else $error("Minus data not on bit two.");
  cap_out_a: assert property (live && $past(capture_unit_two_en && !xcvr_ext_mode
    && !capture_unit_pin_select && !direction_bits[2]) |-> pin_out[2] == $past(capture_unit_two_out))
    else $error("Capture output not on bit three.");
  chip_sel_a: assert property (live && $past(parallel_chip_sel_en && !direction_bits[3])
    |-> pin_oe[3] && pin_out[3] == $past(parallel_chip_sel)) else $error("Chip select not on bit four.");
endmodule
bind pbm_mux pbm_mux_checker u_chk (.core_clk, .rst_b, .clk_en, .output_latch, .direction_bits,
  .pullup_disable_bit, .low_voltage_program_config, .capture_unit_pin_select, .spi_mode,
  .serial_clk_out, .xcvr_ext_mode, .xcvr_minus_data, .capture_unit_two_en, .capture_unit_two_out,
  .parallel_chip_sel_en, .parallel_chip_sel, .pin_out, .pin_oe, .pin_pullup);

/* bench/pbm_pin_model.sv */
// Outside circuitry on the five port pins.
// Assumes pin_oe high means the design drives that pin.
`timescale 1ns/10ps
module pbm_pin_model (
  // Design side of the pads.
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  input wire logic [4:0] pin_pullup,
  // Outside sources set by the bench.
  input wire logic [4:0] ext_drv,
  input wire logic [4:0] ext_val,
  // Resolved pin levels.
  output logic [4:0] pin_level
);
  // A floating pin flips away from its last level so a stale value never passes.
  always @(pin_out or pin_oe or pin_pullup or ext_drv or ext_val) begin
    for (int i = 0; i < 5; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_drv[i]) begin
        pin_level[i] = ext_val[i];
      end else if (pin_pullup[i]) begin
        pin_level[i] = 1'b1;
      end else begin
        pin_level[i] = ~pin_level[i];
      end
    end
  end
endmodule

/* bench/pbm_mux_tb_top.sv */
// Self-checking bench for the port pin multiplexer.
// Assumes inputs driven at the falling edge and a one-edge answer to controls.
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pbm_mux_tb_top;
  // Design inputs.
  logic core_clk, rst_b, clk_en, pullup_disable_bit, analog_select_we, analog_default_config;
  logic [4:0] output_latch, direction_bits, ext_drv, ext_val, pin_level;
  logic [3:0] analog_select_wr, sel;
  logic capture_unit_pin_select, low_voltage_program_config, spi_mode, i2c_mode, serial_clk_out;
  logic i2c_smbus_levels, xcvr_ext_mode, xcvr_minus_data, xcvr_plus_data, capture_unit_two_en;
  logic capture_unit_two_out, parallel_chip_sel_en, parallel_chip_sel;
  // Design outputs.
  logic [4:0] pin_out, pin_oe, pin_pullup, port_input_value, p;
  logic [3:0] analog_enable, analog_channel_map, analog_channel_num;
  logic serial_clk_in, external_interrupt_one, external_interrupt_two;
  logic serial_clk_smbus, capture_unit_two;
  logic change_interrupt_pin_zero, change_interrupt_pin_one, low_voltage_program_entry;
  // Expected channel for port bits 1 to 4.
  logic [3:0] ch_tab [4] = '{4'ha, 4'h8, 4'h9, 4'hb};
  int error_cnt = 0;
  int n_tests = 0;
  pbm_mux u_pbm_mux (.core_clk, .rst_b, .clk_en, .output_latch, .direction_bits,
    .pullup_disable_bit, .analog_select_wr, .analog_select_we, .analog_default_config,
    .capture_unit_pin_select, .low_voltage_program_config, .spi_mode, .i2c_mode, .serial_clk_out,
    .i2c_smbus_levels, .xcvr_ext_mode, .xcvr_minus_data, .xcvr_plus_data, .capture_unit_two_en,
    .capture_unit_two_out, .parallel_chip_sel_en, .parallel_chip_sel, .pin_in(pin_level),
    .pin_out, .pin_oe, .pin_pullup, .analog_enable, .port_input_value, .analog_channel_map,
    .analog_channel_num, .serial_clk_in, .serial_clk_smbus, .external_interrupt_one,
    .external_interrupt_two, .capture_unit_two, .change_interrupt_pin_zero,
    .change_interrupt_pin_one, .low_voltage_program_entry);
  pbm_pin_model u_pbm_pin_model (.pin_out, .pin_oe, .pin_pullup, .ext_drv, .ext_val, .pin_level);
  // 100 MHz core clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Waits n falling edges.
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Loads a new analog selection.
  task automatic sel_write(input logic [3:0] v);
    analog_select_wr = v;
    analog_select_we = 1'b1;
    step(1);
    analog_select_we = 1'b0;
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #200us;
    error_cnt++;
    end_sim();
  end
  // Main sequence.
  initial begin
    {output_latch, pullup_disable_bit, analog_select_wr, analog_select_we, ext_drv, ext_val} = '0;
    {capture_unit_pin_select, low_voltage_program_config, spi_mode, i2c_mode, serial_clk_out} = '0;
    {i2c_smbus_levels, xcvr_ext_mode, xcvr_minus_data, xcvr_plus_data, capture_unit_two_en} = '0;
    {capture_unit_two_out, parallel_chip_sel_en, parallel_chip_sel} = '0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    analog_default_config = 1'b1;
    direction_bits = 5'h1f;
    step(6);
    rst_b = 1'b1;
    step(3);
    `CHK(analog_enable, 4'hf)
    {ext_drv, ext_val} = 10'h3ff;
    step(7);
    `CHK(port_input_value[3:0], 4'h0)
    for (int i = 0; i < 4; i++) begin
      sel = 4'h1 << i;
      sel_write(sel);
      step(3);
      `CHK(analog_channel_num, ch_tab[i])
      `CHK(analog_channel_map, sel)
    end
    $display("Test analog done");
    sel_write(4'h0);
    spi_mode = 1'b1;
    for (int k = 0; k < 2; k++) begin
      p = k ? 5'h0a : 5'h15;
      ext_val = p;
      step(7);
      `CHK(port_input_value, p)
      `CHK({external_interrupt_two, external_interrupt_one}, p[1:0])
      `CHK({change_interrupt_pin_one, change_interrupt_pin_zero}, p[4:3])
      `CHK(serial_clk_in, p[0])
    end
    ext_drv = 5'h00;
    step(2);
    `CHK(pin_pullup, 5'h1f)
    pullup_disable_bit = 1'b1;
    step(2);
    `CHK(pin_pullup, 5'h00)
    $display("Test inputs done");
    spi_mode = 1'b0;
    direction_bits = 5'h00;
    output_latch = 5'h15;
    pullup_disable_bit = 1'b0;
    sel_write(4'hf);
    step(1);
    `CHK(pin_oe, 5'h1f)
    `CHK(pin_out, 5'h15)
    `CHK(pin_pullup, 5'h00)
    // Latch and peripheral values differ on port bits 1 to 4, so each override shows.
    output_latch = 5'h0a;
    {spi_mode, serial_clk_out, xcvr_ext_mode, xcvr_minus_data, xcvr_plus_data} = 5'h1d;
    {parallel_chip_sel_en, parallel_chip_sel} = 2'h2;
    step(2);
    `CHK(pin_out, 5'h05)
    {xcvr_ext_mode, capture_unit_two_en, capture_unit_two_out} = 3'h3;
    step(2);
    `CHK(pin_out[2], 1'b1)
    capture_unit_pin_select = 1'b1;
    step(2);
    `CHK(pin_out[2], 1'b0)
    $display("Test outputs done");
    low_voltage_program_config = 1'b1;
    {ext_drv, ext_val} = 10'h210;
    step(7);
    `CHK({pin_oe[4], low_voltage_program_entry}, 2'b01)
    $display("Test programming pin done");
    // Serial clock input in the second serial mode, buffer select, and capture input.
    spi_mode = 1'b0;
    {i2c_mode, i2c_smbus_levels, capture_unit_pin_select} = 3'h6;
    direction_bits = 5'h1f;
    {ext_drv, ext_val} = 10'h3e5;
    sel_write(4'h0);
    step(7);
    `CHK({serial_clk_smbus, serial_clk_in, capture_unit_two}, 3'h7)
    capture_unit_pin_select = 1'b1;
    step(2);
    `CHK(capture_unit_two, 1'b0)
    direction_bits = 5'h1e;
    serial_clk_out = 1'b1;
    step(2);
    `CHK(pin_out[0], 1'b1)
    // With the enable low the output must hold its old value.
    clk_en = 1'b0;
    serial_clk_out = 1'b0;
    step(2);
    `CHK(pin_out[0], 1'b1)
    clk_en = 1'b1;
    step(2);
    `CHK(pin_out[0], 1'b0)
    $display("Test serial and capture inputs done");
    end_sim();
  end
endmodule
